// ### rtl/scrb_pkg.sv
// Purpose: constants and carriers for the sensor configuration register bank
// Assumes: telegram bits already decoded into command, address, data and parity flags
// Notes: one package shared by the single design file and the sim models
package scrb_pkg;
    localparam int DATA_W = 14;
    localparam int ADDR_W = 4;
    localparam int CMD_W = 3;
    localparam int CURVE_W = 9;
    localparam int CURVE_N = 16;
    // command codes
    localparam logic [2:0] CMD_RD_SETUP = 3'h0;
    localparam logic [2:0] CMD_WR_LOW = 3'h1;
    localparam logic [2:0] CMD_WR_HIGH = 3'h2;
    localparam logic [2:0] CMD_WR_SETUP = 3'h3;
    localparam logic [2:0] CMD_PROGRAM = 3'h4;
    localparam logic [2:0] CMD_ERASE = 3'h5;
    localparam logic [2:0] CMD_RD_LOW = 3'h6;
    localparam logic [2:0] CMD_RD_HIGH = 3'h7;
    // register addresses
    localparam logic [3:0] ADR_CURRENT = 4'h1;
    localparam logic [3:0] ADR_IDENT = 4'h2;
    localparam logic [3:0] ADR_SHIFT = 4'h3;
    localparam logic [3:0] ADR_GAIN = 4'h4;
    localparam logic [3:0] ADR_OPCFG = 4'h5;
    localparam logic [3:0] ADR_LOCK = 4'h6;
    localparam logic [3:0] ADR_READOUT = 4'h7;
    localparam logic [3:0] ADR_OFSCOMP = 4'h8;
    localparam logic [3:0] ADR_SPECIAL = 4'h9;
    localparam logic [3:0] ADR_LINTC = 4'hb;
    localparam logic [3:0] ADR_QUADTC = 4'hc;
    localparam logic [3:0] ADR_DISABLE = 4'hf;
    localparam logic [13:0] DISABLE_KEY = 14'h080f;
    // field layouts
    localparam int SLEW_LSB = 8;
    localparam int LOWCUR_LSB = 3;
    localparam int IDEN_BIT = 4;
    localparam int OFS_EN_BIT = 4;
    localparam int LINTC_W = 7;
    localparam logic [13:0] SPECIAL_RST = 14'h0010;

    // one decoded telegram
    typedef struct packed {
        logic valid;
        logic [2:0] cmd;
        logic [3:0] addr;
        logic [13:0] data;
        logic parity_ok;
    } scrb_tel_type;

    // answer toward the output pin serialiser
    typedef struct packed {
        logic valid;
        logic with_data;
        logic [13:0] data;
        logic parity;
    } scrb_ans_type;

    typedef struct packed {
        logic [9:0] current;
        logic [10:0] ident;
        logic [10:0] shift;
        logic [13:0] gain;
        logic [13:0] opcfg;
        logic lock;
        logic [4:0] ofscomp;
        logic [5:0] special;
        logic [6:0] lintc;
        logic [4:0] quadtc;
    } scrb_setup_type;
endpackage

// ### rtl/scrb_bank.sv
// Purpose: register bank of a programmable magnetic sensor, RAM and nonvolatile copies
// Assumes: telegram framing and bit timing decoded upstream, one telegram per valid pulse
// Notes: power-up is arst_n; nonvolatile setup modelled as registers loaded via straps, setpoint copy cleared
`timescale 1ns/1ps
module scrb_bank
    import scrb_pkg::*;
#(
    parameter int CURVES = CURVE_N
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire scrb_tel_type tel,
    input wire logic activate_pulse,
    input wire logic [11:0] signal_value,
    input wire scrb_setup_type nv_boot_setup,
    output scrb_ans_type ans,
    output scrb_setup_type active_setup,
    output logic offset_comp_enable,
    output logic sensor_active,
    output logic locked,
    output logic charging
);
    // the five-bit setpoint index only serves the documented bank depth
    if (CURVES != CURVE_N) begin : g_depth_check
        $error("scrb_bank: setpoint bank depth must be 16");
    end

    typedef struct packed {
        logic [1:0] rst_sync;
        logic boot_done;
        logic active;
        logic locked;
        logic erased;
        logic charging;
        scrb_setup_type ram;
        scrb_setup_type nv;
        logic [2*CURVE_N*CURVE_W-1:0] curve_ram;
        logic [2*CURVE_N*CURVE_W-1:0] curve_nv;
        scrb_ans_type ans;
    } scrb_state_type;

    scrb_state_type st;
    scrb_state_type next_st;
    logic rst_n;

    assign rst_n = st.rst_sync[1];

    // readback of a setup register, data msb-aligned as the read telegram wants it
    function automatic logic [13:0] read_setup(input scrb_setup_type s, input logic [3:0] a,
                                               input logic [11:0] sig);
        logic [13:0] r;
        r = 14'h0000;
        if (a == ADR_CURRENT) begin
            r = {s.current, 4'h0};
        end else if (a == ADR_IDENT) begin
            r = {s.ident, 3'h0};
        end else if (a == ADR_SHIFT) begin
            r = {s.shift, 3'h0};
        end else if (a == ADR_GAIN) begin
            r = s.gain;
        end else if (a == ADR_OPCFG) begin
            r = s.opcfg;
        end else if (a == ADR_READOUT) begin
            r = {sig, 2'h0};
        end else if (a == ADR_OFSCOMP) begin
            r = {s.ofscomp, 9'h000};
        end else if (a == ADR_SPECIAL) begin
            r = {s.special, 8'h00};
        end else if (a == ADR_LINTC) begin
            r = {s.lintc[5:0], 8'h00};
        end else if (a == ADR_QUADTC) begin
            r = {s.quadtc, 9'h000};
        end
        return r;
    endfunction

    // data parity: one when count of zeros is even
    function automatic logic data_par(input logic [13:0] d);
        return ~^(~d);
    endfunction

    logic [13:0] d;
    logic [8:0] curve_word;
    logic [4:0] curve_idx;

    always_comb begin
        next_st = st;
        // release synchroniser shifts ones in; only its second stage is read
        next_st.rst_sync = {st.rst_sync[0], 1'b1};
        d = tel.data;
        curve_idx = {tel.cmd == CMD_RD_HIGH || tel.cmd == CMD_WR_HIGH, tel.addr};
        curve_word = st.curve_nv[curve_idx*CURVE_W +: CURVE_W];
        next_st.ans = '0;
        // nonvolatile image loads once after power-up; lock only then takes effect
        if (!st.boot_done) begin
            next_st.boot_done = 1'b1;
            next_st.nv = nv_boot_setup;
            next_st.ram = nv_boot_setup;
            next_st.locked = nv_boot_setup.lock;
        end else if (activate_pulse && !st.active) begin
            next_st.active = 1'b1;
        end else if (tel.valid && st.active && tel.parity_ok) begin
            // any command ends a running charge period
            next_st.charging = 1'b0;
            next_st.ans.valid = 1'b1;
            case (tel.cmd)
                CMD_WR_SETUP: begin
                    // only the trailing bits of the field count
                    if (tel.addr == ADR_CURRENT) begin
                        next_st.ram.current = d[9:0];
                    end else if (tel.addr == ADR_IDENT) begin
                        next_st.ram.ident = d[10:0];
                    end else if (tel.addr == ADR_SHIFT) begin
                        next_st.ram.shift = d[10:0];
                    end else if (tel.addr == ADR_GAIN) begin
                        next_st.ram.gain = d;
                    end else if (tel.addr == ADR_OPCFG) begin
                        next_st.ram.opcfg = d;
                    end else if (tel.addr == ADR_LOCK) begin
                        next_st.ram.lock = d[0];
                    end else if (tel.addr == ADR_OFSCOMP) begin
                        next_st.ram.ofscomp = d[4:0];
                    end else if (tel.addr == ADR_SPECIAL) begin
                        next_st.ram.special = d[5:0];
                    end else if (tel.addr == ADR_LINTC) begin
                        next_st.ram.lintc = d[LINTC_W-1:0];
                    end else if (tel.addr == ADR_QUADTC) begin
                        next_st.ram.quadtc = d[4:0];
                    end else if (tel.addr == ADR_DISABLE && d == DISABLE_KEY) begin
                        next_st.active = 1'b0;
                    end
                    // readout address falls through: write ignored
                end
                CMD_WR_LOW, CMD_WR_HIGH: begin
                    next_st.curve_ram[curve_idx*CURVE_W +: CURVE_W] = d[8:0];
                end
                CMD_RD_SETUP: begin
                    // reads return the stored copy, hence commit before readback
                    next_st.ans.with_data = 1'b1;
                    next_st.ans.data = read_setup(st.nv, tel.addr, signal_value);
                end
                CMD_RD_LOW, CMD_RD_HIGH: begin
                    next_st.ans.with_data = 1'b1;
                    next_st.ans.data = {curve_word, 5'h00};
                end
                CMD_ERASE: begin
                    // address ignored; whole array at once
                    if (!st.locked) begin
                        next_st.erased = 1'b1;
                        next_st.charging = 1'b1;
                        next_st.nv = '0;
                        next_st.curve_nv = '0;
                    end
                end
                default: begin
                    // program all: copies every volatile register, lock included
                    if (!st.locked) begin
                        next_st.erased = 1'b0;
                        next_st.charging = 1'b1;
                        next_st.nv = st.ram;
                        next_st.curve_nv = st.curve_ram;
                    end
                end
            endcase
            next_st.ans.parity = data_par(next_st.ans.data);
        end
    end

    // main state register; power-up constants only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.rst_sync <= 2'h0;
            st.boot_done <= 1'b0;
            st.active <= 1'b1;
            st.locked <= 1'b0;
            st.erased <= 1'b0;
            st.charging <= 1'b0;
            st.ram <= '0;
            st.nv <= '0;
            st.curve_ram <= '0;
            st.curve_nv <= '0;
            st.ans <= '0;
        end else if (!rst_n) begin
            st.rst_sync <= next_st.rst_sync;
            st.boot_done <= 1'b0;
        end else begin
            st.rst_sync <= next_st.rst_sync;
            st.boot_done <= next_st.boot_done;
            st.active <= next_st.active;
            st.locked <= next_st.locked;
            st.erased <= next_st.erased;
            st.charging <= next_st.charging;
            st.ram <= next_st.ram;
            st.nv <= next_st.nv;
            st.curve_ram <= next_st.curve_ram;
            st.curve_nv <= next_st.curve_nv;
            st.ans <= next_st.ans;
        end
    end

    // outputs from flip-flops; the signal path uses the stored image
    assign ans = st.ans;
    assign active_setup = st.nv;
    assign offset_comp_enable = st.nv.ofscomp[OFS_EN_BIT];
    assign sensor_active = st.active;
    assign locked = st.locked;
    assign charging = st.charging;

    // checks
    property p_bad_parity_silent;
        @(posedge clk) disable iff (!rst_n)
        (st.boot_done && tel.valid && !tel.parity_ok) |=> !ans.valid;
    endproperty
    a_bad_parity_silent: assert property (p_bad_parity_silent) else $error("ack on bad parity");

    property p_write_ack;
        @(posedge clk) disable iff (!rst_n)
        (st.boot_done && !activate_pulse && tel.valid && tel.parity_ok && st.active
         && tel.cmd == CMD_WR_SETUP) |=> (ans.valid && !ans.with_data);
    endproperty
    a_write_ack: assert property (p_write_ack) else $error("write not acknowledged");

    property p_disable;
        @(posedge clk) disable iff (!rst_n)
        (st.boot_done && !activate_pulse && tel.valid && tel.parity_ok && st.active
         && tel.cmd == CMD_WR_SETUP && tel.addr == ADR_DISABLE && tel.data == DISABLE_KEY)
        |=> !sensor_active;
    endproperty
    a_disable: assert property (p_disable) else $error("disable key ignored");

    property p_inactive_mute;
        @(posedge clk) disable iff (!rst_n)
        (st.boot_done && !sensor_active && !activate_pulse) |=> !ans.valid;
    endproperty
    a_inactive_mute: assert property (p_inactive_mute) else $error("answer while inactive");

    property p_activate;
        @(posedge clk) disable iff (!rst_n)
        (st.boot_done && !sensor_active && activate_pulse) |=> sensor_active;
    endproperty
    a_activate: assert property (p_activate) else $error("activate ignored");

    property p_lock_stable;
        @(posedge clk) disable iff (!rst_n)
        (st.boot_done && locked) |=> $stable(active_setup);
    endproperty
    a_lock_stable: assert property (p_lock_stable) else $error("locked store changed");

    property p_lock_delayed;
        @(posedge clk) disable iff (!rst_n)
        st.boot_done ##1 st.boot_done |-> $stable(locked);
    endproperty
    a_lock_delayed: assert property (p_lock_delayed) else $error("lock changed while on");

    sequence s_program;
        st.boot_done && !activate_pulse && tel.valid && tel.parity_ok && st.active
        && !locked && tel.cmd == CMD_PROGRAM;
    endsequence
    property p_program;
        @(posedge clk) disable iff (!rst_n)
        s_program |=> (charging && active_setup == $past(st.ram));
    endproperty
    a_program: assert property (p_program) else $error("program did not commit");

    property p_readout_ro;
        @(posedge clk) disable iff (!rst_n)
        (st.boot_done && tel.valid && tel.cmd == CMD_WR_SETUP && tel.addr == ADR_READOUT)
        |=> $stable(st.ram);
    endproperty
    a_readout_ro: assert property (p_readout_ro) else $error("readout written");

    property p_parity;
        @(posedge clk) disable iff (!rst_n)
        ans.valid |-> ans.parity == data_par(ans.data);
    endproperty
    a_parity: assert property (p_parity) else $error("answer parity wrong");

    // a lock refuses erase and program: acknowledged, store and charge untouched
    sequence s_store_locked;
        st.boot_done && !activate_pulse && tel.valid && tel.parity_ok && st.active
        && locked && (tel.cmd == CMD_ERASE || tel.cmd == CMD_PROGRAM);
    endsequence
    property p_store_locked;
        @(posedge clk) disable iff (!rst_n)
        s_store_locked |=> (ans.valid && !charging && $stable(active_setup));
    endproperty
    a_store_locked: assert property (p_store_locked) else $error("locked store changed");

    // erase wipes the whole store at once and starts the charge period
    sequence s_erase;
        st.boot_done && !activate_pulse && tel.valid && tel.parity_ok && st.active
        && !locked && tel.cmd == CMD_ERASE;
    endsequence
    property p_erase;
        @(posedge clk) disable iff (!rst_n)
        s_erase |=> (ans.valid && charging && active_setup == '0);
    endproperty
    a_erase: assert property (p_erase) else $error("erase did not clear");

    // every read answers with data and ends a running charge period
    sequence s_read;
        st.boot_done && !activate_pulse && tel.valid && tel.parity_ok && st.active
        && (tel.cmd == CMD_RD_SETUP || tel.cmd == CMD_RD_LOW || tel.cmd == CMD_RD_HIGH);
    endsequence
    property p_read_answer;
        @(posedge clk) disable iff (!rst_n)
        s_read |=> (ans.valid && ans.with_data && !charging);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer wrong");

    // setpoint writes reach only the volatile copy
    sequence s_curve_write;
        st.boot_done && !activate_pulse && tel.valid && tel.parity_ok && st.active
        && (tel.cmd == CMD_WR_LOW || tel.cmd == CMD_WR_HIGH);
    endsequence
    property p_curve_write;
        @(posedge clk) disable iff (!rst_n)
        s_curve_write |=> (ans.valid && !ans.with_data && $stable(st.curve_nv));
    endproperty
    a_curve_write: assert property (p_curve_write) else $error("setpoint write wrong");

    property p_bad_parity_frozen;
        @(posedge clk) disable iff (!rst_n)
        (st.boot_done && tel.valid && !tel.parity_ok)
        |=> ($stable(st.ram) && $stable(st.curve_ram) && $stable(active_setup));
    endproperty
    a_bad_parity_frozen: assert property (p_bad_parity_frozen) else $error("bad telegram used");

    // only the exact key deactivates; a near miss leaves the sensor listening
    property p_near_key;
        @(posedge clk) disable iff (!rst_n)
        (st.boot_done && !activate_pulse && tel.valid && tel.parity_ok && st.active
         && tel.cmd == CMD_WR_SETUP && tel.addr == ADR_DISABLE && tel.data != DISABLE_KEY)
        |=> sensor_active;
    endproperty
    a_near_key: assert property (p_near_key) else $error("wrong key deactivated");

    // rst_n is in the antecedent so the release edge itself never starts an attempt
    property p_boot_load;
        @(posedge clk) disable iff (!rst_n)
        (rst_n && !st.boot_done)
        |=> (active_setup == $past(nv_boot_setup) && locked == $past(nv_boot_setup.lock));
    endproperty
    a_boot_load: assert property (p_boot_load) else $error("boot image not loaded");

    property p_ans_pulse;
        @(posedge clk) disable iff (!rst_n)
        (ans.valid && !tel.valid) |=> !ans.valid;
    endproperty
    a_ans_pulse: assert property (p_ans_pulse) else $error("answer held too long");
endmodule

// ### sim/scrb_prog_model.sv
// Purpose: programmer on the supply line, sends decoded telegrams and judges answers
// Assumes: one telegram at a time, answer read just after the taking edge
// Notes: lines are inverted once released so stale values never look valid
`timescale 1ns/1ps
module scrb_prog_model
    import scrb_pkg::*;
(
    input wire logic clk,
    input wire scrb_ans_type ans,
    output scrb_tel_type tel
);
    initial tel = '0;

    // raise after an edge, hold through the taking edge, then sample the answer
    task automatic send(input logic [2:0] cmd, input logic [3:0] addr, input logic [13:0] data,
            input logic pok, output logic ack, output logic wd, output logic [13:0] rd);
        @(posedge clk);
        tel <= '{valid: 1'b1, cmd: cmd, addr: addr, data: data, parity_ok: pok};
        @(posedge clk);
        tel <= '{valid: 1'b0, cmd: ~cmd, addr: ~addr, data: ~data, parity_ok: 1'b0};
        // the answer stands only for the cycle after the taking edge
        #1;
        ack = (ans.valid === 1'b1);
        wd = ans.with_data;
        rd = ans.data;
        // a garbled answer counts as a failed transfer
        if (ack && (ans.parity !== ~^(~ans.data))) begin
            ack = 1'b0;
        end
    endtask
endmodule

// ### sim/scrb_bank_bench.sv
// Purpose: self-checking bench for the sensor register bank
// Assumes: bench plays the nonvolatile store across power cycles
// Notes: reads return the committed copy, so written values are checked only after a commit
`timescale 1ns/1ps
module scrb_bank_bench
    import scrb_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic activate_pulse = 1'b0;
    logic [11:0] signal_value = 12'ha5c;
    scrb_setup_type nv_boot_setup = '{gain: 14'h1234, default: '0};
    scrb_tel_type tel;
    scrb_ans_type ans;
    scrb_setup_type active_setup;
    logic offset_comp_enable;
    logic sensor_active;
    logic locked;
    logic charging;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;

    scrb_bank scrb_bank_i (.clk(clk), .arst_n(arst_n), .tel(tel),
        .activate_pulse(activate_pulse), .signal_value(signal_value),
        .nv_boot_setup(nv_boot_setup), .ans(ans), .active_setup(active_setup),
        .offset_comp_enable(offset_comp_enable), .sensor_active(sensor_active),
        .locked(locked), .charging(charging));
    scrb_prog_model scrb_prog_model_i (.clk(clk), .ans(ans), .tel(tel));

    always #12.5 clk = ~clk;

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("counts: %0d compared, %0d failed", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // write expects a plain zero acknowledge without data
    task automatic wr(input logic [2:0] cmd, input logic [3:0] addr, input logic [13:0] d);
        logic ack;
        logic wd;
        logic [13:0] rd;
        scrb_prog_model_i.send(cmd, addr, d, 1'b1, ack, wd, rd);
        check("write ack", 14'h0001, {13'h0, ack & ~wd});
    endtask

    task automatic rdchk(input logic [2:0] cmd, input logic [3:0] addr, input logic [13:0] exp);
        logic ack;
        logic wd;
        logic [13:0] rd;
        scrb_prog_model_i.send(cmd, addr, 14'h0000, 1'b1, ack, wd, rd);
        check("read ack", 14'h0001, {13'h0, ack & wd});
        check("read data", exp, rd);
    endtask

    // erase and program carry junk addresses, the closing read ends charging
    // a locked store acknowledges but never starts charging
    task automatic commit(input logic lk);
        wr(CMD_ERASE, 4'ha, 14'h0000);
        wr(CMD_PROGRAM, 4'h3, 14'h0000);
        check("charging", {13'h0, ~lk}, {13'h0, charging});
        rdchk(CMD_RD_SETUP, ADR_READOUT, {signal_value, 2'h0});
        check("charging end", 14'h0000, {13'h0, charging});
    endtask

    task automatic power_up();
        arst_n <= 1'b0;
        repeat (20) @(posedge clk);
        check("active in reset", 14'h0001, {13'h0, sensor_active});
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic t_setup();
        wr(CMD_WR_SETUP, ADR_GAIN, 14'h2abc);
        rdchk(CMD_RD_SETUP, ADR_GAIN, 14'h1234);
        wr(CMD_WR_SETUP, ADR_CURRENT, 14'h3d55);
        wr(CMD_WR_SETUP, ADR_SPECIAL, 14'h0013);
        wr(CMD_WR_SETUP, ADR_SHIFT, 14'h0400);
        wr(CMD_WR_SETUP, ADR_OFSCOMP, 14'h0017);
        wr(CMD_WR_SETUP, ADR_QUADTC, 14'h3fff);
        wr(CMD_WR_SETUP, ADR_OPCFG, 14'h3fff);
        wr(CMD_WR_SETUP, ADR_IDENT, 14'h3abc);
        wr(CMD_WR_SETUP, ADR_LINTC, 14'h005a);
        wr(CMD_WR_SETUP, ADR_READOUT, 14'h0000);
        commit(1'b0);
        rdchk(CMD_RD_SETUP, ADR_GAIN, 14'h2abc);
        rdchk(CMD_RD_SETUP, ADR_CURRENT, {10'h155, 4'h0});
        rdchk(CMD_RD_SETUP, ADR_SPECIAL, {6'h13, 8'h0});
        rdchk(CMD_RD_SETUP, ADR_SHIFT, {11'h400, 3'h0});
        rdchk(CMD_RD_SETUP, ADR_OFSCOMP, {5'h17, 9'h0});
        rdchk(CMD_RD_SETUP, ADR_QUADTC, {5'h1f, 9'h0});
        rdchk(CMD_RD_SETUP, ADR_OPCFG, 14'h3fff);
        rdchk(CMD_RD_SETUP, ADR_IDENT, {11'h2bc, 3'h0});
        rdchk(CMD_RD_SETUP, ADR_LINTC, {6'h1a, 8'h0});
        check("comp enable", 14'h0001, {13'h0, offset_comp_enable});
        check("setup gain", 14'h2abc, active_setup.gain);
        $display("t_setup done");
    endtask

    task automatic t_curve();
        logic ack;
        logic wd;
        logic [13:0] rd;
        scrb_prog_model_i.send(CMD_WR_SETUP, ADR_GAIN, 14'h0001, 1'b0, ack, wd, rd);
        check("bad parity ack", 14'h0000, {13'h0, ack});
        wr(CMD_WR_LOW, 4'h3, 14'h3da5);
        wr(CMD_WR_HIGH, 4'h3, 14'h005a);
        commit(1'b0);
        rdchk(CMD_RD_LOW, 4'h3, {9'h1a5, 5'h0});
        rdchk(CMD_RD_HIGH, 4'h3, {9'h05a, 5'h0});
        rdchk(CMD_RD_SETUP, ADR_GAIN, 14'h2abc);
        $display("t_curve done");
    endtask

    task automatic t_disable();
        logic ack;
        logic wd;
        logic [13:0] rd;
        wr(CMD_WR_SETUP, ADR_DISABLE, 14'h080e);
        check("active near key", 14'h0001, {13'h0, sensor_active});
        wr(CMD_WR_SETUP, ADR_DISABLE, DISABLE_KEY);
        check("inactive", 14'h0000, {13'h0, sensor_active});
        scrb_prog_model_i.send(CMD_RD_SETUP, ADR_GAIN, 14'h0000, 1'b1, ack, wd, rd);
        check("ignored read", 14'h0000, {13'h0, ack});
        @(posedge clk);
        activate_pulse <= 1'b1;
        @(posedge clk);
        activate_pulse <= 1'b0;
        repeat (2) @(posedge clk);
        check("reactivated", 14'h0001, {13'h0, sensor_active});
        rdchk(CMD_RD_SETUP, ADR_GAIN, 14'h2abc);
        $display("t_disable done");
    endtask

    task automatic t_lock();
        wr(CMD_WR_SETUP, ADR_LOCK, 14'h0001);
        commit(1'b0);
        check("lock waits", 14'h0000, {13'h0, locked});
        // leave the sensor deactivated so the power cycle must wake it
        wr(CMD_WR_SETUP, ADR_DISABLE, DISABLE_KEY);
        @(posedge clk);
        nv_boot_setup <= active_setup;
        power_up();
        check("locked", 14'h0001, {13'h0, locked});
        wr(CMD_WR_SETUP, ADR_GAIN, 14'h0000);
        commit(1'b1);
        rdchk(CMD_RD_SETUP, ADR_GAIN, 14'h2abc);
        $display("t_lock done");
    endtask

    initial begin
        power_up();
        t_setup();
        t_curve();
        t_disable();
        t_lock();
        wrap_up();
    end
endmodule
